// [rtl/cpu_exec_pkg.sv]
// Constants and types for the arithmetic, logic and jump execution unit.
// Assumes a single clock and an instruction decoder outside this unit.
package cpu_exec_pkg;

  // ********************************************
  // Instruction selection
  // ********************************************
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM,
    OP_SUB, OP_REG_MINUS_IMM, OP_REG_MINUS_REG_BORROW,
    OP_REG_MINUS_IMM_BORROW, OP_AND, OP_AND_WITH_IMM, OP_OR,
    OP_OR_WITH_IMM, OP_XOR_REGS, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM,
    OP_ZERO_MINUS_TEST, OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED,
    OP_PRODUCT_SIGNED_UNSIGNED, OP_FRACTION_PRODUCT_UNSIGNED,
    OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED,
    OP_JUMP_VIA_POINTER, OP_SUBROUTINE_VIA_POINTER,
    OP_COMPARE_SKIP_EQUAL, OP_COMPARE_IMMEDIATE, OP_SKIP_BIT_CLEAR
  } op_e;

  // ********************************************
  // Flag positions and update masks
  // ********************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_W = 6;
  localparam logic [5:0] FLAGS_RESET = 6'h00;
  localparam logic [5:0] MASK_ARITH8 = 6'h2F;
  localparam logic [5:0] MASK_WORD = 6'h1F;
  localparam logic [5:0] MASK_LOGIC = 6'h0E;
  localparam logic [5:0] MASK_PRODUCT = 6'h03;
  localparam logic [5:0] MASK_NONE = 6'h00;

  // ********************************************
  // Operand constants and cycle counts
  // ********************************************
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam int WORD_IMM_W = 6;
  localparam int PC_W = 16;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] SKIP_SHORT = 16'h0002;
  localparam logic [15:0] SKIP_LONG = 16'h0003;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_CALL = 3'h4;

endpackage

// [rtl/cpu_arith_logic_jump_exec.sv]
// Execution unit for arithmetic, logic, multiply, jump and skip work.
// Assumes the decoder issues one op when ready_o is high, operands valid.
//
// Summary of operation
// - Register add, optional carry in, sets Z C N V H, one cycle.
// - Word plus immediate writes the pair, sets Z C N V S, two cycles.
// - Word minus immediate writes the pair, sets Z C N V S, two cycles.
// - Register subtract, optional borrow, sets Z C N V H, one cycle.
// - Register minus constant stored, sets Z C N V H, one cycle.
// - Register minus constant minus carry stored, sets Z C N V H.
// - AND with register or constant, updates only Z N V, one cycle.
// - OR with register or constant, updates only Z N V, one cycle.
// - Set bits ORs register with mask, updates Z N V, one cycle.
// - Clear bits ANDs with 0xFF minus constant, updates Z N V.
// - Test ANDs register with itself, value kept, updates Z N V.
// - Integer products go to the product pair, set Z C, two cycles.
// - Fractional products shifted left once, set Z C, two cycles.
// - Pointer jump loads program counter, no flags, two cycles.
// - Pointer call loads program counter, no flags, four cycles.
// - Compare-skip-equal advances counter by 2 or 3 on match.
// - Compare immediate subtracts without storing, sets Z N V C H.
// - Skip-bit-clear advances counter by 2 or 3 when bit is zero.
`timescale 1ns/1ps
module cpu_arith_logic_jump_exec (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic issue_i,
  input wire cpu_exec_pkg::op_e op_i,
  input wire logic [7:0] rd_i,
  input wire logic [7:0] rr_i,
  input wire logic [7:0] imm_i,
  input wire logic [15:0] pair_i,
  input wire logic [15:0] ptr_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic next_long_i,
  output logic ready_o,
  output logic done_o,
  output logic [7:0] res8_o,
  output logic res8_we_o,
  output logic [15:0] res16_o,
  output logic pair_we_o,
  output logic prod_we_o,
  output logic push_o,
  output logic [15:0] pc_o,
  output logic flag_c_o,
  output logic flag_z_o,
  output logic flag_n_o,
  output logic flag_v_o,
  output logic flag_s_o,
  output logic flag_h_o
);
  import cpu_exec_pkg::*;

  // ********************************************
  // Byte adder shared by add, subtract, compare
  // ********************************************
  // Returns {h, v, c, result}
  function automatic logic [10:0] addsub8(input logic [7:0] a,
      input logic [7:0] b, input logic ci, input logic sub);
    logic [8:0] r9;
    logic h;
    logic v;
    r9 = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, ci})
             : ({1'b0, a} + {1'b0, b} + {8'h00, ci});
    if (sub) begin
      h = (~a[3] & b[3]) | (b[3] & r9[3]) | (r9[3] & ~a[3]);
      v = (a[7] & ~b[7] & ~r9[7]) | (~a[7] & b[7] & r9[7]);
    end else begin
      h = (a[3] & b[3]) | (b[3] & ~r9[3]) | (~r9[3] & a[3]);
      v = (a[7] & b[7] & ~r9[7]) | (~a[7] & ~b[7] & r9[7]);
    end
    return {h, v, r9[8], r9[7:0]};
  endfunction

  // ********************************************
  // Operation evaluation
  // ********************************************
  logic [10:0] as_r;
  logic [16:0] w17;
  logic [17:0] mul_r;
  logic [15:0] prod;
  logic [7:0] log_r;
  logic [5:0] c_flags;
  logic [5:0] c_mask;
  logic [7:0] c_res8;
  logic [15:0] c_res16;
  logic c_we8, c_wep, c_wepr, c_push;
  logic [15:0] c_pc;
  logic [2:0] c_cyc;
  logic [5:0] flags_q;
  logic [15:0] pc_q;
  logic sa, sb;

  always_comb begin
    as_r = addsub8(rd_i, rr_i, 1'b0, 1'b0);
    w17 = 17'h0_0000;
    mul_r = 18'h0_0000;
    prod = 16'h0000;
    log_r = rd_i & rr_i;
    sa = 1'b0;
    sb = 1'b0;
    c_flags = flags_q;
    c_mask = MASK_NONE;
    c_res8 = 8'h00;
    c_res16 = 16'h0000;
    c_we8 = 1'b0;
    c_wep = 1'b0;
    c_wepr = 1'b0;
    c_push = 1'b0;
    c_pc = pc_q + PC_STEP;
    c_cyc = CYC_ONE;
    case (op_i)
      OP_ADD, OP_ADD_CARRY: begin
        as_r = addsub8(rd_i, rr_i,
                       (op_i == OP_ADD_CARRY) & flags_q[FLAG_C], 1'b0);
        c_mask = MASK_ARITH8;
        c_we8 = 1'b1;
      end
      OP_SUB, OP_REG_MINUS_REG_BORROW: begin
        as_r = addsub8(rd_i, rr_i,
                       (op_i == OP_REG_MINUS_REG_BORROW) & flags_q[FLAG_C],
                       1'b1);
        c_mask = MASK_ARITH8;
        c_we8 = 1'b1;
      end
      OP_REG_MINUS_IMM, OP_REG_MINUS_IMM_BORROW: begin
        as_r = addsub8(rd_i, imm_i,
                       (op_i == OP_REG_MINUS_IMM_BORROW) & flags_q[FLAG_C],
                       1'b1);
        c_mask = MASK_ARITH8;
        c_we8 = 1'b1;
      end
      OP_COMPARE_IMMEDIATE: begin
        as_r = addsub8(rd_i, imm_i, 1'b0, 1'b1);
        c_mask = MASK_ARITH8;
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
        if (op_i == OP_WORD_PLUS_IMM) begin
          w17 = {1'b0, pair_i} + {11'h000, imm_i[WORD_IMM_W-1:0]};
          c_flags[FLAG_V] = ~pair_i[15] & w17[15];
          c_flags[FLAG_C] = ~w17[15] & pair_i[15];
        end else begin
          w17 = {1'b0, pair_i} - {11'h000, imm_i[WORD_IMM_W-1:0]};
          c_flags[FLAG_V] = pair_i[15] & ~w17[15];
          c_flags[FLAG_C] = w17[15] & ~pair_i[15];
        end
        c_flags[FLAG_N] = w17[15];
        c_flags[FLAG_Z] = (w17[15:0] == 16'h0000);
        c_flags[FLAG_S] = w17[15] ^ c_flags[FLAG_V];
        c_mask = MASK_WORD;
        c_res16 = w17[15:0];
        c_wep = 1'b1;
        c_cyc = CYC_TWO;
      end
      OP_AND, OP_AND_WITH_IMM, OP_OR, OP_OR_WITH_IMM, OP_XOR_REGS,
      OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_ZERO_MINUS_TEST: begin
        case (op_i)
          OP_AND: log_r = rd_i & rr_i;
          OP_AND_WITH_IMM: log_r = rd_i & imm_i;
          OP_OR: log_r = rd_i | rr_i;
          OP_OR_WITH_IMM, OP_SET_BITS_IMM: log_r = rd_i | imm_i;
          OP_XOR_REGS: log_r = rd_i ^ rr_i;
          OP_CLEAR_BITS_IMM: log_r = rd_i & (BYTE_ALL_ONES - imm_i);
          default: log_r = rd_i & rd_i;
        endcase
        c_flags[FLAG_Z] = (log_r == 8'h00);
        c_flags[FLAG_N] = log_r[7];
        c_flags[FLAG_V] = 1'b0;
        c_mask = MASK_LOGIC;
        c_res8 = log_r;
        c_we8 = 1'b1;
      end
      OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_UNSIGNED,
      OP_FRACTION_PRODUCT_UNSIGNED, OP_FRACTION_PRODUCT_SIGNED,
      OP_FRACTION_PRODUCT_MIXED: begin
        sa = (op_i == OP_PRODUCT_SIGNED) |
             (op_i == OP_PRODUCT_SIGNED_UNSIGNED) |
             (op_i == OP_FRACTION_PRODUCT_SIGNED) |
             (op_i == OP_FRACTION_PRODUCT_MIXED);
        sb = (op_i == OP_PRODUCT_SIGNED) |
             (op_i == OP_FRACTION_PRODUCT_SIGNED);
        // Full-width sign extension keeps the low product bits exact
        mul_r = {{10{rd_i[7] & sa}}, rd_i} *
                {{10{rr_i[7] & sb}}, rr_i};
        // Carry is the top bit before the fractional shift
        c_flags[FLAG_C] = mul_r[15];
        prod = (op_i >= OP_FRACTION_PRODUCT_UNSIGNED) ?
               {mul_r[14:0], 1'b0} : mul_r[15:0];
        c_flags[FLAG_Z] = (prod == 16'h0000);
        c_mask = MASK_PRODUCT;
        c_res16 = prod;
        c_wepr = 1'b1;
        c_cyc = CYC_TWO;
      end
      OP_JUMP_VIA_POINTER: begin
        c_pc = ptr_i;
        c_cyc = CYC_TWO;
      end
      OP_SUBROUTINE_VIA_POINTER: begin
        c_pc = ptr_i;
        c_res16 = pc_q + PC_STEP;
        c_push = 1'b1;
        c_cyc = CYC_CALL;
      end
      OP_COMPARE_SKIP_EQUAL, OP_SKIP_BIT_CLEAR: begin
        if ((op_i == OP_COMPARE_SKIP_EQUAL) ? (rd_i == rr_i)
                                             : ~rr_i[bit_sel_i]) begin
          c_pc = pc_q + (next_long_i ? SKIP_LONG : SKIP_SHORT);
          c_cyc = next_long_i ? CYC_THREE : CYC_TWO;
        end
      end
      default: c_mask = MASK_NONE;
    endcase
    if (c_mask == MASK_ARITH8) begin
      c_res8 = as_r[7:0];
      c_flags[FLAG_C] = as_r[8];
      c_flags[FLAG_V] = as_r[9];
      c_flags[FLAG_H] = as_r[10];
      c_flags[FLAG_Z] = (as_r[7:0] == 8'h00);
      c_flags[FLAG_N] = as_r[7];
    end
    c_flags = (flags_q & ~c_mask) | (c_flags & c_mask);
  end

  // ********************************************
  // Sequencing and commit
  // ********************************************
  typedef enum logic {ST_IDLE, ST_RUN} state_e;
  state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [5:0] pf_q, pf_d;
  logic [7:0] p8_q, p8_d;
  logic [15:0] p16_q, p16_d, ppc_q, ppc_d;
  logic [3:0] pwe_q, pwe_d;
  logic [5:0] flags_d;
  logic [15:0] pc_d, res16_d;
  logic [7:0] res8_d;
  logic [3:0] we_d, we_q;
  logic ready_d, done_d, commit, acc;

  assign acc = issue_i & ready_o;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    pf_d = pf_q;
    p8_d = p8_q;
    p16_d = p16_q;
    ppc_d = ppc_q;
    pwe_d = pwe_q;
    flags_d = flags_q;
    pc_d = pc_q;
    res8_d = res8_o;
    res16_d = res16_o;
    we_d = 4'h0;
    commit = 1'b0;
    if (state_q == ST_IDLE) begin
      if (acc) begin
        if (c_cyc == CYC_ONE) begin
          commit = 1'b1;
          flags_d = c_flags;
          pc_d = c_pc;
          res8_d = c_res8;
          res16_d = c_res16;
          we_d = {c_push, c_wepr, c_wep, c_we8};
        end else begin
          state_d = ST_RUN;
          cnt_d = c_cyc - CYC_ONE;
          pf_d = c_flags;
          p8_d = c_res8;
          p16_d = c_res16;
          ppc_d = c_pc;
          pwe_d = {c_push, c_wepr, c_wep, c_we8};
        end
      end
    end else begin
      cnt_d = cnt_q - CYC_ONE;
      // Results held back so flags and counter move on the last cycle
      if (cnt_q == CYC_ONE) begin
        commit = 1'b1;
        state_d = ST_IDLE;
        flags_d = pf_q;
        pc_d = ppc_q;
        res8_d = p8_q;
        res16_d = p16_q;
        we_d = pwe_q;
      end
    end
    ready_d = (state_d == ST_IDLE);
    done_d = commit;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      pf_q <= FLAGS_RESET;
      p8_q <= 8'h00;
      p16_q <= 16'h0000;
      ppc_q <= PC_RESET;
      pwe_q <= 4'h0;
      flags_q <= FLAGS_RESET;
      pc_q <= PC_RESET;
      res8_o <= 8'h00;
      res16_o <= 16'h0000;
      we_q <= 4'h0;
      ready_o <= 1'b1;
      done_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pf_q <= pf_d;
      p8_q <= p8_d;
      p16_q <= p16_d;
      ppc_q <= ppc_d;
      pwe_q <= pwe_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      res8_o <= res8_d;
      res16_o <= res16_d;
      we_q <= we_d;
      ready_o <= ready_d;
      done_o <= done_d;
    end
  end

  assign res8_we_o = we_q[0];
  assign pair_we_o = we_q[1];
  assign prod_we_o = we_q[2];
  assign push_o = we_q[3];
  assign pc_o = pc_q;
  assign flag_c_o = flags_q[FLAG_C];
  assign flag_z_o = flags_q[FLAG_Z];
  assign flag_n_o = flags_q[FLAG_N];
  assign flag_v_o = flags_q[FLAG_V];
  assign flag_s_o = flags_q[FLAG_S];
  assign flag_h_o = flags_q[FLAG_H];

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  add_one_cycle_a: assert property (
    acc && op_i == OP_ADD |=> done_o && res8_we_o &&
      res8_o == 8'($past(rd_i) + $past(rr_i)))
    else $error("byte add not done in one cycle");
  word_two_cycle_a: assert property (
    acc && op_i == OP_WORD_PLUS_IMM |=> !done_o ##1 done_o && pair_we_o)
    else $error("word add not done in two cycles");
  word_sign_flag_a: assert property (
    pair_we_o |-> flag_s_o == (flag_n_o ^ flag_v_o))
    else $error("word sign flag wrong");
  logic_flags_a: assert property (
    acc && op_i == OP_AND |=> !flag_v_o && $stable(flag_c_o) &&
      $stable(flag_h_o))
    else $error("logic op flags wrong");
  product_timing_a: assert property (
    acc && op_i == OP_PRODUCT_UNSIGNED |=> !done_o ##1 prod_we_o &&
      res16_o == {8'h00, $past(rd_i, 2)} * {8'h00, $past(rr_i, 2)})
    else $error("product wrong or late");
  jump_load_a: assert property (
    acc && op_i == OP_JUMP_VIA_POINTER |=> ##1 done_o &&
      pc_o == $past(ptr_i, 2))
    else $error("pointer jump wrong");
  call_timing_a: assert property (
    acc && op_i == OP_SUBROUTINE_VIA_POINTER |=> !done_o [*3] ##1
      done_o && push_o && pc_o == $past(ptr_i, 4))
    else $error("pointer call wrong");
  compare_nostore_a: assert property (
    acc && op_i == OP_COMPARE_IMMEDIATE |=> done_o && !res8_we_o)
    else $error("compare stored a result");
  skip_long_a: assert property (
    acc && op_i == OP_SKIP_BIT_CLEAR && !rr_i[bit_sel_i] && next_long_i
    |=> !done_o [*2] ##1 done_o && pc_o == $past(pc_o, 3) + 16'h0003)
    else $error("long skip wrong");
  skip_not_taken_a: assert property (
    acc && op_i == OP_COMPARE_SKIP_EQUAL && rd_i != rr_i
    |=> done_o && pc_o == $past(pc_o) + 16'h0001)
    else $error("untaken skip wrong");

endmodule

// [tb/exec_far_side.sv]
// Far-side model: register file catching the unit's write strobes.
// Assumes strobes are one-cycle pulses on the unit's clock.
`timescale 1ns/1ps
module exec_far_side (
  input wire logic clk_i,
  input wire logic res8_we_i,
  input wire logic [7:0] res8_i,
  input wire logic pair_we_i,
  input wire logic prod_we_i,
  input wire logic push_i,
  input wire logic [15:0] res16_i,
  output logic [7:0] byte_o,
  output logic [15:0] pair_o,
  output logic [15:0] prod_o,
  output logic [15:0] ret_o
);
  // Only strobed data lands, so a stray value never reaches the file
  always_ff @(posedge clk_i) begin
    if (res8_we_i) byte_o <= res8_i;
    if (pair_we_i) pair_o <= res16_i;
    if (prod_we_i) prod_o <= res16_i;
    if (push_i) ret_o <= res16_i;
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the execution unit and its far-side model.
// Assumes one clock at 40 MHz and a synchronous active-low reset.
`timescale 1ns/1ps
module tb;
  import cpu_exec_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic issue_i = 1'b0;
  op_e op_i = OP_ADD;
  logic [7:0] rd_i = 8'h00, rr_i = 8'h00, imm_i = 8'h00;
  logic [15:0] pair_i = 16'h0000, ptr_i = 16'h0000;
  logic [2:0] bit_sel_i = 3'h0;
  logic next_long_i = 1'b0;
  logic ready_o, done_o, res8_we_o, pair_we_o, prod_we_o, push_o;
  logic flag_c_o, flag_z_o, flag_n_o, flag_v_o, flag_s_o, flag_h_o;
  logic [7:0] res8_o, byte_q;
  logic [15:0] res16_o, pc_o, pair_q, prod_q, ret_q;
  logic [15:0] w_pair = 16'h0000, w_ptr = 16'h0000;
  logic [2:0] w_bit = 3'h0;
  logic w_long = 1'b0;
  logic [5:0] fl, ef;
  int errors = 0;
  int checks = 0;
  int lat;
  assign fl = {flag_h_o, flag_s_o, flag_v_o, flag_n_o, flag_z_o, flag_c_o};
  always #12.5 clk_i = ~clk_i;
  cpu_arith_logic_jump_exec i_cpu_arith_logic_jump_exec (.clk_i(clk_i),
    .rstn_i(rstn_i), .issue_i(issue_i), .op_i(op_i), .rd_i(rd_i),
    .rr_i(rr_i), .imm_i(imm_i), .pair_i(pair_i), .ptr_i(ptr_i),
    .bit_sel_i(bit_sel_i), .next_long_i(next_long_i), .ready_o(ready_o),
    .done_o(done_o), .res8_o(res8_o), .res8_we_o(res8_we_o),
    .res16_o(res16_o), .pair_we_o(pair_we_o), .prod_we_o(prod_we_o),
    .push_o(push_o), .pc_o(pc_o), .flag_c_o(flag_c_o),
    .flag_z_o(flag_z_o), .flag_n_o(flag_n_o), .flag_v_o(flag_v_o),
    .flag_s_o(flag_s_o), .flag_h_o(flag_h_o));
  exec_far_side i_exec_far_side (.clk_i(clk_i), .res8_we_i(res8_we_o),
    .res8_i(res8_o), .pair_we_i(pair_we_o), .prod_we_i(prod_we_o),
    .push_i(push_o), .res16_i(res16_o), .byte_o(byte_q), .pair_o(pair_q),
    .prod_o(prod_q), .ret_o(ret_q));

  // ********************************************
  // Shared tasks
  // ********************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Issue one op; lat counts edges until done shows, bounded
  task automatic run(input op_e op, input logic [7:0] a, b, k);
    @(posedge clk_i);
    issue_i <= 1'b1;
    op_i <= op;
    rd_i <= a;
    rr_i <= b;
    imm_i <= k;
    pair_i <= w_pair;
    ptr_i <= w_ptr;
    bit_sel_i <= w_bit;
    next_long_i <= w_long;
    @(posedge clk_i);
    issue_i <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk_i);
      lat++;
    end while (done_o !== 1'b1 && lat < 10);
    // One more edge so the far-side file has caught the strobe
    @(negedge clk_i);
  endtask

  // Byte add or subtract: returns flags H S V N Z C then result
  function automatic logic [13:0] arith(input logic [7:0] a, b,
                                        input logic ci, sub,
                                        input logic [5:0] f);
    logic [7:0] r;
    logic [4:0] hn;
    logic c, v;
    {c, r} = sub ? {1'b0, a} - {1'b0, b} - ci : {1'b0, a} + {1'b0, b} + ci;
    hn = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - ci
             : {1'b0, a[3:0]} + {1'b0, b[3:0]} + ci;
    v = (sub ? a[7] ^ b[7] : ~(a[7] ^ b[7])) & (a[7] ^ r[7]);
    return {hn[4], f[FLAG_S], v, r[7], r == 8'h00, c, r};
  endfunction

  // ********************************************
  // Scenarios
  // ********************************************
  task automatic t_byte();
    op_e ops[7] = '{OP_ADD, OP_ADD_CARRY, OP_SUB, OP_REG_MINUS_REG_BORROW,
      OP_REG_MINUS_IMM, OP_REG_MINUS_IMM_BORROW, OP_COMPARE_IMMEDIATE};
    logic [15:0] opd[7] = '{16'h7F01, 16'hFF01, 16'h1020, 16'h0001,
      16'h8001, 16'h2323, 16'h050F};
    logic [13:0] e;
    logic [7:0] a, b, last;
    logic im, cy, sb;
    foreach (ops[i]) foreach (opd[j]) begin
      a = opd[j][15:8];
      b = opd[j][7:0];
      im = ops[i] inside {OP_REG_MINUS_IMM, OP_REG_MINUS_IMM_BORROW,
        OP_COMPARE_IMMEDIATE};
      cy = ops[i] inside {OP_ADD_CARRY, OP_REG_MINUS_REG_BORROW,
        OP_REG_MINUS_IMM_BORROW};
      sb = !(ops[i] inside {OP_ADD, OP_ADD_CARRY});
      e = arith(a, b, cy & ef[FLAG_C], sb, ef);
      run(ops[i], a, im ? ~b : b, im ? b : ~b);
      ef = e[13:8];
      if (ops[i] != OP_COMPARE_IMMEDIATE) last = e[7:0];
      chk(fl, ef);
      chk(16'(lat), 16'h0001);
      chk(byte_q, last);
    end
    $display("test byte arithmetic finished");
  endtask

  task automatic t_logic();
    op_e ops[8] = '{OP_AND, OP_AND_WITH_IMM, OP_OR, OP_OR_WITH_IMM,
      OP_XOR_REGS, OP_SET_BITS_IMM, OP_CLEAR_BITS_IMM, OP_ZERO_MINUS_TEST};
    logic [7:0] a, b, r;
    logic im;
    foreach (ops[i]) begin
      // Preload C, H and V so that kept and cleared flags both show
      run(OP_ADD, 8'h88, 8'h88, 8'h00);
      ef = (ef & 6'h10) | 6'h29;
      a = 8'hC6 >> i;
      b = 8'h5A;
      im = ops[i] inside {OP_AND_WITH_IMM, OP_OR_WITH_IMM, OP_SET_BITS_IMM,
        OP_CLEAR_BITS_IMM};
      case (ops[i])
        OP_AND, OP_AND_WITH_IMM: r = a & b;
        OP_XOR_REGS: r = a ^ b;
        OP_CLEAR_BITS_IMM: r = a & (8'hFF - b);
        OP_ZERO_MINUS_TEST: r = a;
        default: r = a | b;
      endcase
      run(ops[i], a, im ? ~b : b, im ? b : ~b);
      ef = {ef[5:4], 1'b0, r[7], r == 8'h00, ef[0]};
      chk(fl, ef);
      chk(16'(lat), 16'h0001);
      if (ops[i] != OP_ZERO_MINUS_TEST) chk(byte_q, r);
    end
    $display("test logic finished");
  endtask

  task automatic t_word();
    logic [15:0] p[5] = '{16'hFFFF, 16'h7FFF, 16'h0000, 16'h8000, 16'h1234};
    logic [7:0] k[5] = '{8'hC1, 8'hC1, 8'hC1, 8'hC1, 8'hFF};
    logic [15:0] r;
    logic pl, c, v;
    foreach (p[i]) begin
      pl = i inside {0, 1, 4};
      r = pl ? p[i] + {10'h000, k[i][5:0]} : p[i] - {10'h000, k[i][5:0]};
      c = pl ? ~r[15] & p[i][15] : r[15] & ~p[i][15];
      v = pl ? ~p[i][15] & r[15] : p[i][15] & ~r[15];
      w_pair = p[i];
      run(pl ? OP_WORD_PLUS_IMM : OP_WORD_MINUS_IMM, 8'h00, 8'h00, k[i]);
      ef = {ef[5], r[15] ^ v, v, r[15], r == 16'h0000, c};
      chk(fl, ef);
      chk(16'(lat), 16'h0002);
      chk(pair_q, r);
    end
    $display("test word finished");
  endtask

  task automatic t_product();
    op_e ops[6] = '{OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED,
      OP_PRODUCT_SIGNED_UNSIGNED, OP_FRACTION_PRODUCT_UNSIGNED,
      OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED};
    logic [15:0] opd[4] = '{16'hFFFF, 16'h8080, 16'h80FF, 16'h0012};
    logic [15:0] x, y, p, r;
    logic sa, sb, fr;
    foreach (ops[i]) foreach (opd[j]) begin
      sa = !(ops[i] inside {OP_PRODUCT_UNSIGNED,
        OP_FRACTION_PRODUCT_UNSIGNED});
      sb = ops[i] inside {OP_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_SIGNED};
      fr = i > 2;
      x = {{8{sa & opd[j][15]}}, opd[j][15:8]};
      y = {{8{sb & opd[j][7]}}, opd[j][7:0]};
      p = x * y;
      r = fr ? p << 1 : p;
      run(ops[i], opd[j][15:8], opd[j][7:0], 8'h00);
      ef = {ef[5:2], r == 16'h0000, p[15]};
      chk(fl, ef);
      chk(16'(lat), 16'h0002);
      chk(prod_q, r);
    end
    $display("test product finished");
  endtask

  task automatic t_flow();
    logic [15:0] pc0, n;
    logic [7:0] v;
    logic cs, tk;
    v = 8'hA5;
    w_ptr = 16'h1234;
    run(OP_JUMP_VIA_POINTER, 8'h00, 8'h00, 8'h00);
    chk(pc_o, 16'h1234);
    chk(16'(lat), 16'h0002);
    chk(fl, ef);
    pc0 = pc_o;
    w_ptr = 16'h0F0F;
    run(OP_SUBROUTINE_VIA_POINTER, 8'h00, 8'h00, 8'h00);
    chk(pc_o, 16'h0F0F);
    chk(ret_q, pc0 + 16'h0001);
    chk(16'(lat), 16'h0004);
    chk(fl, ef);
    for (int k = 0; k < 12; k++) begin
      cs = k < 4;
      w_bit = k[2:0];
      w_long = k[1];
      tk = cs ? k[0] : ~v[k[2:0]];
      n = tk ? (w_long ? 16'h0003 : 16'h0002) : 16'h0001;
      pc0 = pc_o;
      if (cs) run(OP_COMPARE_SKIP_EQUAL, v, k[0] ? v : ~v, 8'h00);
      else run(OP_SKIP_BIT_CLEAR, v, v, 8'h00);
      chk(pc_o, pc0 + n);
      chk(16'(lat), n);
      chk(fl, ef);
    end
    $display("test flow finished");
  endtask

  // Reset cuts a running call; the cut op must never commit
  task automatic t_reset();
    w_ptr = 16'h0ABC;
    @(posedge clk_i);
    issue_i <= 1'b1;
    op_i <= OP_SUBROUTINE_VIA_POINTER;
    ptr_i <= w_ptr;
    @(posedge clk_i);
    issue_i <= 1'b0;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(negedge clk_i);
    chk(pc_o, 16'h0000);
    chk(fl, 6'h00);
    chk({ready_o, done_o, push_o}, 16'h0004);
    repeat (3) @(negedge clk_i);
    chk({ready_o, done_o, push_o}, 16'h0004);
    chk(pc_o, 16'h0000);
    ef = 6'h00;
    run(OP_ADD, 8'h01, 8'h02, 8'h00);
    chk(byte_q, 16'h0003);
    chk(fl, ef);
    chk(16'(lat), 16'h0001);
    $display("test reset finished");
  endtask

  // ********************************************
  // Main sequence and watchdog
  // ********************************************
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    ef = 6'h00;
    @(negedge clk_i);
    chk(fl, 6'h00);
    chk(pc_o, 16'h0000);
    chk(ready_o, 1'b1);
    t_byte();
    t_logic();
    t_word();
    t_product();
    t_flow();
    t_reset();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    errors++;
    test_done();
  end
endmodule
